// ---- logic/sre_pkg.sv ----
package sre_pkg;
    // fixed device code in the top nibble of the control byte
    localparam logic [3:0] DEV_CODE = 4'ha;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    // bit count at which a byte is complete
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam int FIFO_DEPTH = 32;
    // link timing, host side
    localparam int CLK_PERIOD_NS = 25;
    localparam int QUARTER_NS = 1250;
    localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] PH_SET = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;
    typedef enum logic {SRE_CURRENT, SRE_RANDOM} sre_kind_t;
endpackage

// ---- logic/sre_link_if.sv ----
`timescale 1ns/1ps
interface sre_link_if;
    logic scl;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic sda;

    // wired-and with pull-up; an enable low means that end drives
    assign sda = (sdaHostOe | sdaHostOut) & (sdaDevOe | sdaDevOut);

    modport host (output scl, output sdaHostOut, output sdaHostOe, input sda);
    modport dev (input scl, input sda, output sdaDevOut, output sdaDevOe);
endinterface

// ---- logic/sre_fifo.sv ----
`timescale 1ns/1ps
module sre_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic outValid_q, outValid_d;
    logic [W-1:0] outData_q, outData_d;
    logic push, load;

    // depth is assumed a power of two so pointers wrap by themselves
    always_comb
    begin
        inReady = cnt_q < (AW+1)'(DEPTH);
        push = inValid && inReady;
        load = (cnt_q != '0) && (!outValid_q || outReady);
        wp_d = push ? wp_q + AW'(1) : wp_q;
        rp_d = load ? rp_q + AW'(1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
        outValid_d = load || (outValid_q && !outReady);
        outData_d = load ? mem[rp_q] : outData_q;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            outValid_q <= 1'b0;
            outData_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            outValid_q <= outValid_d;
            outData_q <= outData_d;
        end
    end

    // storage needs no reset
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[wp_q] <= inData;
        end
    end

    assign outValid = outValid_q;
    assign outData = outData_q;
endmodule

// ---- logic/sre_device.sv ----
`timescale 1ns/1ps
module sre_device #(
    parameter int AW = sre_pkg::ADDR_W
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic linkClk,
    sre_link_if.dev lnk,
    input wire logic [sre_pkg::SEL_W-1:0] chipSel,
    input wire logic progBusy,
    input wire logic loadValid,
    input wire logic [AW-1:0] loadAddr,
    input wire logic [sre_pkg::DATA_W-1:0] loadData,
    output logic loadReady
);
    localparam int DW = sre_pkg::DATA_W;
    localparam int SW = sre_pkg::SEL_W;

    typedef enum logic [2:0] {
        D_IDLE, D_CTRL, D_ACKC, D_ADDR, D_WDATA, D_ACKW, D_TX, D_MACK
    } sre_dstate_t;

    function automatic logic [3:0] inc4(input logic [3:0] v);
        return v + 4'h1;
    endfunction

    // ---------------- user side, ref_clk: memory preload ----------------
    logic loadReady_q, loadReady_d;
    logic reqTgl_q, reqTgl_d;
    logic [AW-1:0] ldAddr_q, ldAddr_d;
    logic [DW-1:0] ldData_q, ldData_d;
    logic ackS1, ackS2, ackTgl_q;

    // address and data stay frozen while a toggle is in flight,
    // so the link side may read them without its own crossing
    always_comb
    begin
        reqTgl_d = reqTgl_q;
        ldAddr_d = ldAddr_q;
        ldData_d = ldData_q;
        loadReady_d = (ackS2 == reqTgl_q);
        if (loadValid && loadReady_q)
        begin
            reqTgl_d = !reqTgl_q;
            ldAddr_d = loadAddr;
            ldData_d = loadData;
            loadReady_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {loadReady_q, reqTgl_q, ldAddr_q, ldData_q, ackS1, ackS2} <= '0;
        end
        else
        begin
            loadReady_q <= loadReady_d;
            reqTgl_q <= reqTgl_d;
            ldAddr_q <= ldAddr_d;
            ldData_q <= ldData_d;
            ackS1 <= ackTgl_q;
            ackS2 <= ackS1;
        end
    end

    // ---------------- link side, linkClk ----------------
    logic sclS1, sclS2, sclP, sdaS1, sdaS2, sdaP;
    logic [SW-1:0] selS1, selS2;
    logic busyS1, busyS2, reqS1, reqS2;
    logic [DW-1:0] mem [2**AW];

    // pins, straps and the busy level all pass two flops first
    always_ff @(posedge linkClk or negedge nrst)
    begin
        if (!nrst)
        begin
            {sclS1, sclS2, sclP, sdaS1, sdaS2, sdaP} <= '1;
            {selS1, selS2, busyS1, busyS2, reqS1, reqS2, ackTgl_q} <= '0;
        end
        else
        begin
            {sclP, sclS2, sclS1} <= {sclS2, sclS1, lnk.scl};
            {sdaP, sdaS2, sdaS1} <= {sdaS2, sdaS1, lnk.sda};
            {selS2, selS1} <= {selS1, chipSel};
            {busyS2, busyS1} <= {busyS1, progBusy};
            {ackTgl_q, reqS2, reqS1} <= {reqS2, reqS1, reqTgl_q};
        end
    end

    // preload write lands when the request toggle arrives
    always_ff @(posedge linkClk)
    begin
        if (reqS2 != ackTgl_q)
            mem[ldAddr_q] <= ldData_q;
    end

    logic startSeen, stopSeen, sclRise, sclFall, fetch, ctrlMatch;
    sre_dstate_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [DW-1:0] sh_q, sh_d, tx_q, tx_d;
    logic [AW-1:0] ptr_q, ptr_d;
    logic rw_q, rw_d, oe_q, oe_d, mack_q, mack_d;

    // bus conditions from synchronised samples only
    always_comb
    begin
        startSeen = sclS2 && sclP && sdaP && !sdaS2;
        stopSeen = sclS2 && sclP && !sdaP && sdaS2;
        sclRise = sclS2 && !sclP;
        sclFall = !sclS2 && sclP;
        ctrlMatch = (sh_q[7:4] == sre_pkg::DEV_CODE) && (sh_q[3:1] == selS2);
    end

    // byte engine; data changes only while scl is low
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        oe_d = oe_q;
        mack_d = mack_q;
        fetch = 1'b0;
        if (startSeen)
        begin
            // a start at any point abandons a pending write
            state_d = D_CTRL;
            cnt_d = '0;
            oe_d = 1'b1;
        end
        else if (stopSeen)
        begin
            state_d = D_IDLE;
            oe_d = 1'b1;
        end
        else if (sclRise)
        begin
            if ((state_q == D_CTRL || state_q == D_ADDR || state_q == D_WDATA)
                && cnt_q != sre_pkg::BYTE_BITS)
            begin
                sh_d = {sh_q[DW-2:0], sdaS2};
                cnt_d = inc4(cnt_q);
            end
            if (state_q == D_MACK)
                mack_d = sdaS2;
        end
        else if (sclFall)
        begin
            unique case (state_q)
                D_IDLE: ;
                D_CTRL:
                    if (cnt_q == sre_pkg::BYTE_BITS)
                    begin
                        if (ctrlMatch && !busyS2)
                        begin
                            oe_d = 1'b0;
                            rw_d = sh_q[0];
                            state_d = D_ACKC;
                        end
                        else
                            state_d = D_IDLE;
                    end
                D_ACKC:
                    if (rw_q == sre_pkg::RW_READ)
                        fetch = 1'b1;
                    else
                    begin
                        oe_d = 1'b1;
                        cnt_d = '0;
                        state_d = D_ADDR;
                    end
                D_ADDR:
                    if (cnt_q == sre_pkg::BYTE_BITS)
                    begin
                        ptr_d = sh_q[AW-1:0];
                        oe_d = 1'b0;
                        state_d = D_ACKW;
                    end
                D_WDATA:
                    // write data is acknowledged but never stored here
                    if (cnt_q == sre_pkg::BYTE_BITS)
                    begin
                        oe_d = 1'b0;
                        state_d = D_ACKW;
                    end
                D_ACKW:
                begin
                    oe_d = 1'b1;
                    cnt_d = '0;
                    state_d = D_WDATA;
                end
                D_TX:
                    if (cnt_q == sre_pkg::BYTE_BITS)
                    begin
                        oe_d = 1'b1;
                        state_d = D_MACK;
                    end
                    else
                    begin
                        oe_d = tx_q[DW-1];
                        tx_d = {tx_q[DW-2:0], 1'b0};
                        cnt_d = inc4(cnt_q);
                    end
                D_MACK:
                    if (!mack_q)
                        fetch = 1'b1;
                    else
                    begin
                        oe_d = 1'b1;
                        state_d = D_IDLE;
                    end
            endcase
        end
        // first bit goes out on the same falling edge as the fetch
        if (fetch)
        begin
            oe_d = mem[ptr_q][DW-1];
            tx_d = {mem[ptr_q][DW-2:0], 1'b0};
            ptr_d = ptr_q + AW'(1);
            cnt_d = 4'h1;
            state_d = D_TX;
        end
    end

    always_ff @(posedge linkClk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= D_IDLE;
            {cnt_q, sh_q, tx_q, ptr_q, rw_q} <= '0;
            {oe_q, mack_q} <= 2'h3;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            mack_q <= mack_d;
        end
    end

    // open drain: only the enable moves, the level is always low
    assign lnk.sdaDevOut = 1'b0;
    assign lnk.sdaDevOe = oe_q;
    assign loadReady = loadReady_q;
endmodule

// ---- logic/sre_host.sv ----
`timescale 1ns/1ps
module sre_host #(
    parameter int QUARTER = sre_pkg::QUARTER_CYC,
    parameter int DEPTH = sre_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic nrst,
    sre_link_if.host lnk,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire sre_pkg::sre_kind_t cmdKind,
    input wire logic [sre_pkg::SEL_W-1:0] cmdSel,
    input wire logic [sre_pkg::ADDR_W-1:0] cmdAddr,
    input wire logic [7:0] cmdLen,
    output logic rdValid,
    input wire logic rdReady,
    output logic [sre_pkg::DATA_W-1:0] rdData,
    output logic nackSeen
);
    localparam int DW = sre_pkg::DATA_W;

    typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} sre_hstate_t;
    typedef enum logic [1:0] {S_WCTRL, S_ADDR, S_RCTRL, S_READ} sre_step_t;

    function automatic logic [DW-1:0] ctrlByte(input logic [2:0] sel, input logic rw);
        return {sre_pkg::DEV_CODE, sel, rw};
    endfunction

    sre_hstate_t st_q, st_d;
    sre_step_t step_q, step_d;
    logic [15:0] qc_q, qc_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [DW-1:0] tx_q, tx_d, rx_q, rx_d;
    logic [2:0] sel_q, sel_d;
    logic [sre_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] left_q, left_d;
    logic scl_q, scl_d, oe_q, oe_d, cmdReady_q, cmdReady_d, nack_q, nack_d;
    logic sdaS1, sdaS2, tick, stall, push, fifoInReady, writing;

    // the device answers from its own clock, so sda is resynchronised
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sdaS1 <= 1'b1;
            sdaS2 <= 1'b1;
        end
        else
        begin
            sdaS1 <= lnk.sda;
            sdaS2 <= sdaS1;
        end
    end

    // quarter-bit sequencer; scl is divided down from ref_clk
    always_comb
    begin
        st_d = st_q;
        step_d = step_q;
        qc_d = qc_q;
        ph_d = ph_q;
        bit_d = bit_q;
        tx_d = tx_q;
        rx_d = rx_q;
        sel_d = sel_q;
        addr_d = addr_q;
        left_d = left_q;
        scl_d = scl_q;
        oe_d = oe_q;
        cmdReady_d = cmdReady_q;
        nack_d = 1'b0;
        writing = (step_q != S_READ);
        // full fifo holds scl low before a read byte begins
        stall = st_q == H_BYTE && !writing && bit_q == '0 && ph_q == sre_pkg::PH_SET
            && !fifoInReady;
        tick = (qc_q == 16'(QUARTER - 1)) && !stall;
        push = tick && st_q == H_BYTE && !writing && bit_q == sre_pkg::BYTE_BITS
            && ph_q == sre_pkg::PH_SAMPLE;
        if (st_q != H_IDLE && !stall)
        begin
            qc_d = tick ? '0 : qc_q + 16'h1;
        end
        if (st_q == H_IDLE && cmdValid && cmdReady_q)
        begin
            cmdReady_d = 1'b0;
            sel_d = cmdSel;
            addr_d = cmdAddr;
            left_d = cmdLen;
            step_d = (cmdKind == sre_pkg::SRE_RANDOM) ? S_WCTRL : S_RCTRL;
            st_d = H_START;
            ph_d = sre_pkg::PH_SET;
        end
        else if (tick)
        begin
            ph_d = ph_q + 2'h1;
            unique case (st_q)
                H_IDLE: ;
                H_START:
                    unique case (ph_q)
                        sre_pkg::PH_SET: oe_d = 1'b1;
                        sre_pkg::PH_RISE: scl_d = 1'b1;
                        sre_pkg::PH_SAMPLE: oe_d = 1'b0;
                        sre_pkg::PH_FALL:
                        begin
                            scl_d = 1'b0;
                            st_d = H_BYTE;
                            bit_d = '0;
                            tx_d = ctrlByte(sel_q, step_q == S_RCTRL);
                        end
                    endcase
                H_BYTE:
                    unique case (ph_q)
                        sre_pkg::PH_SET:
                            if (bit_q != sre_pkg::BYTE_BITS)
                                oe_d = writing ? tx_q[DW-1] : 1'b1;
                            else
                                oe_d = writing ? 1'b1 : (left_q == '0);
                        sre_pkg::PH_RISE: scl_d = 1'b1;
                        sre_pkg::PH_SAMPLE: rx_d = {rx_q[DW-2:0], sdaS2};
                        sre_pkg::PH_FALL:
                        begin
                            scl_d = 1'b0;
                            bit_d = bit_q + 4'h1;
                            tx_d = {tx_q[DW-2:0], 1'b0};
                            if (bit_q == sre_pkg::BYTE_BITS)
                            begin
                                bit_d = '0;
                                if (writing && rx_q[0])
                                begin
                                    nack_d = 1'b1;
                                    st_d = H_STOP;
                                end
                                else
                                    unique case (step_q)
                                        S_WCTRL:
                                        begin
                                            step_d = S_ADDR;
                                            tx_d = addr_q;
                                        end
                                        S_ADDR:
                                        begin
                                            step_d = S_RCTRL;
                                            st_d = H_START;
                                        end
                                        S_RCTRL: step_d = S_READ;
                                        S_READ:
                                            if (left_q == '0)
                                                st_d = H_STOP;
                                            else
                                                left_d = left_q - 8'h1;
                                    endcase
                            end
                        end
                    endcase
                H_STOP:
                    unique case (ph_q)
                        sre_pkg::PH_SET: oe_d = 1'b0;
                        sre_pkg::PH_RISE: scl_d = 1'b1;
                        sre_pkg::PH_SAMPLE: oe_d = 1'b1;
                        sre_pkg::PH_FALL:
                        begin
                            st_d = H_IDLE;
                            cmdReady_d = 1'b1;
                        end
                    endcase
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= H_IDLE;
            step_q <= S_RCTRL;
            qc_q <= '0;
            ph_q <= '0;
            bit_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
            sel_q <= '0;
            addr_q <= '0;
            left_q <= '0;
            scl_q <= 1'b1;
            oe_q <= 1'b1;
            cmdReady_q <= 1'b1;
            nack_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            step_q <= step_d;
            qc_q <= qc_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            sel_q <= sel_d;
            addr_q <= addr_d;
            left_q <= left_d;
            scl_q <= scl_d;
            oe_q <= oe_d;
            cmdReady_q <= cmdReady_d;
            nack_q <= nack_d;
        end
    end

    // read bytes queue here; room was checked before the byte began
    sre_fifo #(
        .W(DW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .inValid(push),
        .inReady(fifoInReady),
        .inData(rx_q),
        .outValid(rdValid),
        .outReady(rdReady),
        .outData(rdData)
    );

    assign lnk.scl = scl_q;
    assign lnk.sdaHostOut = 1'b0;
    assign lnk.sdaHostOe = oe_q;
    assign cmdReady = cmdReady_q;
    assign nackSeen = nack_q;
endmodule

// ---- sim/sre_checker.sv ----
`timescale 1ns/1ps
// watches the link lines, both drive enables and the chip strap
module sre_checker (
    input logic ref_clk,
    input logic nrst,
    input logic linkClk,
    input logic scl,
    input logic sdaHostOe,
    input logic sdaDevOe,
    input logic sda,
    input logic [2:0] chipSel
);
    logic sclQ, sdaQ, rdQ, rdD, fstQ, fstD;
    logic [3:0] cntQ, cntD;
    logic [7:0] shQ, shD;
    wire rise = scl && !sclQ;
    // bit position in the byte, restarted by every start
    always_comb
    begin
        {cntD, shD, rdD, fstD} = {cntQ, shQ, rdQ, fstQ};
        if (scl && sclQ && sdaQ && !sda)
        begin
            {cntD, shD, rdD, fstD} = {4'h0, 8'h0, 1'b0, 1'b1};
        end
        else if (rise)
        begin
            shD = {shQ[6:0], sda};
            cntD = (cntQ == 4'h8) ? 4'h0 : cntQ + 4'h1;
            fstD = fstQ && (cntQ != 4'h8);
            rdD = (fstQ && cntQ == 4'h7) ? sda : rdQ;
        end
    end
    // idle lines reset high so no false edge after release
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            {sclQ, sdaQ, rdQ, fstQ, cntQ, shQ} <= {2'h3, 14'h0};
        else
            {sclQ, sdaQ, rdQ, fstQ, cntQ, shQ} <= {scl, sda, rdD, fstD, cntD, shD};
    end
    property p_devStable;
        @(posedge linkClk) disable iff (!nrst) scl && $past(scl) |-> $stable(sdaDevOe);
    endproperty
    a_devStable: assert property (p_devStable) else $error("device moved sda with scl high");
    property p_startByHost;
        @(posedge ref_clk) disable iff (!nrst) scl && $fell(sda) |-> !sdaHostOe && sdaDevOe;
    endproperty
    a_startByHost: assert property (p_startByHost) else $error("start not made by host");
    property p_idleAfterStop;
        @(posedge ref_clk) disable iff (!nrst) scl && $rose(sda) |-> sdaDevOe [*8];
    endproperty
    a_idleAfterStop: assert property (p_idleAfterStop) else $error("device drives at stop");
    property p_writeQuiet;
        @(posedge ref_clk) disable iff (!nrst) rise && !rdQ && cntQ != 4'h8 |-> sdaDevOe;
    endproperty
    a_writeQuiet: assert property (p_writeQuiet) else $error("device drives host bit");
    property p_foreign;
        @(posedge ref_clk) disable iff (!nrst)
            rise && fstQ && cntQ == 4'h8 && shQ[7:1] != {sre_pkg::DEV_CODE, chipSel} |-> sdaDevOe;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign code acknowledged");
    property p_nackRelease;
        @(posedge ref_clk) disable iff (!nrst) rise && rdQ && !fstQ && cntQ == 4'h8 |-> sdaDevOe;
    endproperty
    a_nackRelease: assert property (p_nackRelease) else $error("device holds ack slot");
    property p_sclHigh;
        @(posedge ref_clk) disable iff (!nrst) $rose(scl) |-> scl [*8];
    endproperty
    a_sclHigh: assert property (p_sclHigh) else $error("scl high too short");
    property p_sclLow;
        @(posedge ref_clk) disable iff (!nrst) $fell(scl) |-> !scl [*8];
    endproperty
    a_sclLow: assert property (p_sclLow) else $error("scl low too short");
    c_ack: cover property (@(posedge ref_clk) rise && fstQ && cntQ == 4'h8 && !sdaDevOe);
    c_seq: cover property (@(posedge ref_clk) rise && rdQ && !fstQ && cntQ == 4'h8 && !sda);
    c_stop: cover property (@(posedge ref_clk) scl && $rose(sda));
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic linkClk = 1'b0;
    logic nrst = 1'b0;
    logic cmdValid = 1'b0;
    sre_pkg::sre_kind_t cmdKind = sre_pkg::SRE_CURRENT;
    logic [2:0] cmdSel = 3'h0, chipSel = 3'h0;
    logic [7:0] cmdAddr = 8'h0, cmdLen = 8'h0, loadAddr = 8'h0, loadData = 8'h0;
    logic rdReady = 1'b0, progBusy = 1'b0, loadValid = 1'b0;
    logic cmdReady, rdValid, nackSeen, loadReady;
    logic [7:0] rdData, ptr;
    logic [7:0] mem [256];
    logic [31:0] seed = 32'h3b8d53d7;
    int mismatches = 0;
    int cmp_count = 0;
    sre_link_if lnk ();
    sre_host #(.QUARTER(40)) sre_host_inst (.ref_clk(ref_clk), .nrst(nrst), .lnk(lnk.host),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdSel(cmdSel),
        .cmdAddr(cmdAddr), .cmdLen(cmdLen), .rdValid(rdValid), .rdReady(rdReady),
        .rdData(rdData), .nackSeen(nackSeen));
    sre_device sre_device_inst (.ref_clk(ref_clk), .nrst(nrst), .linkClk(linkClk),
        .lnk(lnk.dev), .chipSel(chipSel), .progBusy(progBusy), .loadValid(loadValid),
        .loadAddr(loadAddr), .loadData(loadData), .loadReady(loadReady));
    sre_checker sre_checker_inst (.ref_clk(ref_clk), .nrst(nrst), .linkClk(linkClk),
        .scl(lnk.scl), .sdaHostOe(lnk.sdaHostOe), .sdaDevOe(lnk.sdaDevOe), .sda(lnk.sda),
        .chipSel(chipSel));
    // both clocks
    always #12.5 ref_clk = ~ref_clk;
    // its edges meet a ref_clk edge every 400 ns, and the phases drift apart in between
    always #80 linkClk = ~linkClk;
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one read command; consumer stalls at random, or fully for hold cycles
    task rd(input sre_pkg::sre_kind_t k, input logic [2:0] s, input logic [7:0] a,
        input logic [7:0] len, input logic nk, input int hold);
        int n;
        int t;
        logic nf;
        n = 0;
        t = 0;
        nf = 1'b0;
        cmdKind = k;
        cmdSel = s;
        cmdAddr = a;
        cmdLen = len;
        cmdValid = 1'b1;
        @(posedge ref_clk);
        #2;
        cmdValid = 1'b0;
        if (k == sre_pkg::SRE_RANDOM && !nk)
            ptr = a;
        while (!(cmdReady && !rdValid))
        begin
            // settled values, as the coming rising edge will take them
            @(negedge ref_clk);
            if (rdValid && rdReady)
            begin
                chk("rdData", rdData, mem[ptr]);
                ptr++;
                n++;
            end
            nf = nf | nackSeen;
            if (hold > 0 && t == hold)
                chk("sclStall", {7'h0, lnk.scl}, 8'h0);
            @(posedge ref_clk);
            #2;
            seed = lfsr(seed);
            rdReady = (t >= hold) && seed[0];
            t++;
        end
        chk("count", n[7:0], nk ? 8'h0 : len + 8'h1);
        chk("nack", {7'h0, nf}, {7'h0, nk});
    endtask
    // main sequence: preload, then read kinds and refusals
    initial
    begin
        repeat (12) @(posedge ref_clk);
        #2;
        seed = lfsr(seed);
        chipSel = seed[2:0];
        ptr = 8'h0;
        nrst = 1'b1;
        for (int i = 0; i < 256; i++)
        begin
            @(posedge ref_clk);
            #2;
            seed = lfsr(seed);
            mem[i] = seed[7:0];
            loadAddr = i[7:0];
            loadData = seed[7:0];
            loadValid = 1'b1;
            // ready judged where settled; the next rising edge takes the byte
            @(negedge ref_clk);
            while (!loadReady)
                @(negedge ref_clk);
            @(posedge ref_clk);
            #2;
            loadValid = 1'b0;
        end
        rd(sre_pkg::SRE_RANDOM, chipSel, seed[15:8], 8'h2, 1'b0, 0);
        rd(sre_pkg::SRE_CURRENT, chipSel, 8'h0, 8'h0, 1'b0, 0);
        rd(sre_pkg::SRE_RANDOM, chipSel, 8'hfe, 8'h2, 1'b0, 0);
        rd(sre_pkg::SRE_CURRENT, chipSel ^ 3'h1, 8'h0, 8'h0, 1'b1, 0);
        progBusy = 1'b1;
        rd(sre_pkg::SRE_RANDOM, chipSel, 8'h40, 8'h0, 1'b1, 0);
        progBusy = 1'b0;
        rd(sre_pkg::SRE_CURRENT, chipSel, 8'h0, 8'h22, 1'b0, 51000);
        end_of_test;
    end
    // hang guard sized from the longest expected run
    initial
    begin
        repeat (97000) @(posedge ref_clk);
        mismatches++;
        end_of_test;
    end
endmodule
